/* inc/fdt_defs.vh */
/*
 constants for the delimiter timestamp pulse block: register offsets,
 field positions, reset values and timing figures.
 assumes inclusion by bare name from design files only.
*/
`ifndef FDT_DEFS_VH
`define FDT_DEFS_VH

`define FDT_REG_PHY_CONTROL 9'h01F
`define FDT_REG_SKEW_STATUS 9'h055
`define FDT_REG_ALIGN_CTRL 9'h0E9
`define FDT_REG_RX_CONFIG 9'h134
`define FDT_REG_PIN_SELECT 9'h1E0
`define FDT_REG_PHASE 9'h1E1

`define FDT_SOFT_RESTART_BIT 14
`define FDT_EXT_MAC_EN_BIT 7
`define FDT_ALIGN_INIT_VALUE 16'hDF22
`define FDT_PHY_CONTROL_RST 16'h0000
`define FDT_ALIGN_CTRL_RST 16'h0000
`define FDT_RX_CONFIG_RST 16'h0000
`define FDT_PIN_SELECT_RST 16'h0000
`define FDT_PHASE_RST 16'h0000

`define FDT_PIN_SEL_TX 4'h1
`define FDT_PIN_SEL_RX 4'h2
`define FDT_PIN_SEL_OFF 4'h0

`define FDT_PHASE_STEP_NS 8
`define FDT_CLK_PERIOD_NS 8
`define FDT_PHASE_STEP_CYC ((`FDT_PHASE_STEP_NS + `FDT_CLK_PERIOD_NS - 1) / `FDT_CLK_PERIOD_NS)

`endif

/* rtl/fdt_frame_delimiter_pulse.v */
/*
 delimiter indication pulses for transmit and receive paths with phase
 adjust, pin routing, pair skew limiting and skew status readout.
 assumes a register port from the management block on the same 125 MHz
 clock; line side events arrive as single-cycle strobes on that clock.
 the 32-tap delay lines bound phase plus held skew to 31 cycles.
 link state inputs come from logic on this same clock, so no synchronisers.
*/
// Function
// - separate delimiter pulses for transmit and receive frames, for timestamping.
// - transmit pulse marks delimiter on line; receive pulse marks first symbol.
// - software phase value shifts pulses, one unit per 8 ns.
// - pin function register at 1E0h routes pulses to output pins.
// - pulses leave only while extended MAC features bit at 134h is set.
// - control bit 14 at 1Fh restarts link without full reset.
// - master gigabit role reports added delay in status bits 7:4.
// - slave gigabit role reports added delay in status bits 3:0.
// - added receive delay stays constant during one uninterrupted link.
// - added delay changes only when a new link is established.
// - skew limiting and reporting act only at 1000Mb.
// - at 100Mb no skew readout and no compensation.
`timescale 1ns/1ps
`include "fdt_defs.vh"

module fdt_frame_delimiter_pulse #(
  parameter PHASE_W = 4,
  parameter SKEW_W = 4,
  parameter DLY_DEPTH = 32
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [8:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  input wire i_tx_delim,
  input wire i_rx_first_sym,
  input wire i_link_up,
  input wire i_speed_1000,
  input wire i_role_master,
  input wire [SKEW_W-1:0] i_pair_skew,
  output wire o_soft_link_restart,
  output reg o_transmit_delimiter_pulse,
  output reg o_receive_delimiter_pulse,
  output reg [1:0] o_pin_sfd
);

  localparam DLY_W = 6;

  // software visible registers
  reg [15:0] phy_control_q;
  reg [15:0] align_ctrl_q;
  reg [15:0] rx_config_q;
  reg [15:0] pin_select_q;
  reg [PHASE_W-1:0] phase_q;
  // held skew and link tracking
  reg [SKEW_W-1:0] skew_master_q;
  reg [SKEW_W-1:0] skew_slave_q;
  reg [SKEW_W-1:0] skew_hold_q;
  reg link_q;
  reg restart_q;
  // one tap per cycle delay lines
  reg [DLY_DEPTH-1:0] tx_line_q;
  reg [DLY_DEPTH-1:0] rx_line_q;

  // derived controls
  wire ext_en = rx_config_q[`FDT_EXT_MAC_EN_BIT];
  wire align_ok = (align_ctrl_q == `FDT_ALIGN_INIT_VALUE);
  wire new_link = i_link_up & ~link_q;
  wire [DLY_W-1:0] tx_dly;
  wire [DLY_W-1:0] rx_dly;
  localparam integer STEP_CYC = `FDT_PHASE_STEP_CYC;
  // phase unit in whole cycles, cut to the delay width on purpose
  wire [31:0] step_full = STEP_CYC;
  wire [DLY_W-1:0] step = step_full[DLY_W-1:0];
  // full-width product and sum so no carry is lost before the cut
  wire [2*DLY_W-1:0] tx_prod;
  wire [DLY_W:0] rx_sum;
  wire [DLY_W-1:0] skew_add;
  wire tx_tap;
  wire rx_tap;
  wire [1:0] pin_d;

  // address match helper
  function hit;
    input [8:0] a;
    input [8:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // source chosen by one pin select nibble
  function pin_src;
    input [3:0] sel;
    input tx_v;
    input rx_v;
    begin
      case (sel)
        `FDT_PIN_SEL_TX: pin_src = tx_v;
        `FDT_PIN_SEL_RX: pin_src = rx_v;
        default: pin_src = 1'b0;
      endcase
    end
  endfunction

  // phase steps of 8 ns map to whole clock cycles
  assign tx_prod = {{DLY_W{1'b0}}, step} * {{(2*DLY_W-PHASE_W){1'b0}}, phase_q};
  assign tx_dly = tx_prod[DLY_W-1:0]; // phase at most 15 units fits
  // receive also carries the held pair skew, already zero outside gigabit
  assign skew_add = {{(DLY_W-SKEW_W){1'b0}}, skew_hold_q};
  assign rx_sum = {1'b0, tx_dly} + {1'b0, skew_add};
  assign rx_dly = rx_sum[DLY_W-1:0]; // phase plus skew stays below 32
  // tap of each delay line picked by its delay
  assign tx_tap = tx_line_q[tx_dly[4:0]];
  assign rx_tap = rx_line_q[rx_dly[4:0]];
  assign o_soft_link_restart = restart_q;

  // one routing slice per output pin, one select nibble per pin
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : pin_route
      assign pin_d[gp] = ext_en & pin_src(pin_select_q[4*gp+3:4*gp], tx_tap, rx_tap);
    end
  endgenerate

  // register writes and self-clearing restart
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      phy_control_q <= `FDT_PHY_CONTROL_RST;
      align_ctrl_q <= `FDT_ALIGN_CTRL_RST;
      rx_config_q <= `FDT_RX_CONFIG_RST;
      pin_select_q <= `FDT_PIN_SELECT_RST;
      phase_q <= {PHASE_W{1'b0}};
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      phy_control_q[`FDT_SOFT_RESTART_BIT] <= 1'b0; // self-clearing
      if (i_reg_wr) begin
        if (hit(i_reg_addr, `FDT_REG_PHY_CONTROL)) begin
          phy_control_q <= i_reg_wdata & ~(16'h0001 << `FDT_SOFT_RESTART_BIT);
          restart_q <= i_reg_wdata[`FDT_SOFT_RESTART_BIT];
        end
        if (hit(i_reg_addr, `FDT_REG_ALIGN_CTRL))
          align_ctrl_q <= i_reg_wdata;
        if (hit(i_reg_addr, `FDT_REG_RX_CONFIG))
          rx_config_q <= i_reg_wdata;
        if (hit(i_reg_addr, `FDT_REG_PIN_SELECT))
          pin_select_q <= i_reg_wdata;
        if (hit(i_reg_addr, `FDT_REG_PHASE))
          phase_q <= i_reg_wdata[PHASE_W-1:0];
      end
    end
  end

  // skew captured once per new link, held for the link lifetime
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      link_q <= 1'b0;
      skew_hold_q <= {SKEW_W{1'b0}};
      skew_master_q <= {SKEW_W{1'b0}};
      skew_slave_q <= {SKEW_W{1'b0}};
    end else begin
      link_q <= i_link_up & ~restart_q;
      if (new_link & ~restart_q) begin
        if (i_speed_1000 & align_ok) begin
          skew_hold_q <= i_pair_skew;
          skew_master_q <= i_role_master ? i_pair_skew : {SKEW_W{1'b0}};
          skew_slave_q <= i_role_master ? {SKEW_W{1'b0}} : i_pair_skew;
        end else begin
          skew_hold_q <= {SKEW_W{1'b0}};
          skew_master_q <= {SKEW_W{1'b0}};
          skew_slave_q <= {SKEW_W{1'b0}};
        end
      end
      // otherwise unchanged while link stays up
    end
  end

  // delay lines, one tap per cycle
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_line_q <= {DLY_DEPTH{1'b0}};
      rx_line_q <= {DLY_DEPTH{1'b0}};
    end else begin
      tx_line_q <= {tx_line_q[DLY_DEPTH-2:0], i_tx_delim};
      rx_line_q <= {rx_line_q[DLY_DEPTH-2:0], i_rx_first_sym};
    end
  end

  // one-cycle gated pulses and pin routing
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_transmit_delimiter_pulse <= 1'b0;
      o_receive_delimiter_pulse <= 1'b0;
      o_pin_sfd <= 2'b00;
    end else begin
      o_transmit_delimiter_pulse <= ext_en & tx_tap;
      o_receive_delimiter_pulse <= ext_en & rx_tap;
      o_pin_sfd <= pin_d;
    end
  end

  // registered read data, unmapped reads zero
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `FDT_REG_PHY_CONTROL: o_reg_rdata <= phy_control_q;
        `FDT_REG_SKEW_STATUS: o_reg_rdata <= {8'h00, skew_master_q, skew_slave_q};
        `FDT_REG_ALIGN_CTRL: o_reg_rdata <= align_ctrl_q;
        `FDT_REG_RX_CONFIG: o_reg_rdata <= rx_config_q;
        `FDT_REG_PIN_SELECT: o_reg_rdata <= pin_select_q;
        `FDT_REG_PHASE: o_reg_rdata <= {{(16-PHASE_W){1'b0}}, phase_q};
        default: o_reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

/* testbench/fdt_chk_assertions.sv */
/* port checker for the delimiter pulse block.
 bound to the block from the bench; sees its ports only. */
`timescale 1ns/1ps
module fdt_chk (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [8:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  input wire i_tx_delim,
  input wire o_soft_link_restart,
  input wire o_transmit_delimiter_pulse,
  input wire o_receive_delimiter_pulse,
  input wire [1:0] o_pin_sfd
);
  logic [5:0] idle_q;
  // restart request seen on the register port
  wire rs_wr = i_reg_wr && i_reg_addr == 9'h01F && i_reg_wdata[14];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // cycles since the last transmit delimiter, saturating
  always @(posedge i_clk) idle_q <= (i_sys_rst || i_tx_delim) ? 6'h00 : idle_q + {5'h00, idle_q != 6'h3F};
  a_tx_width: assert property (o_transmit_delimiter_pulse |=> !o_transmit_delimiter_pulse) else $error("tx long");
  a_rx_width: assert property (o_receive_delimiter_pulse |=> !o_receive_delimiter_pulse) else $error("rx long");
  a_pin0_width: assert property (o_pin_sfd[0] |=> !o_pin_sfd[0]) else $error("pin0 long");
  a_pin1_width: assert property (o_pin_sfd[1] |=> !o_pin_sfd[1]) else $error("pin1 long");
  a_restart_cause: assert property (rs_wr |=> o_soft_link_restart ##1 !o_soft_link_restart) else $error("no restart");
  a_restart_only: assert property (o_soft_link_restart |-> $past(rs_wr)) else $error("stray restart");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
  a_tx_quiet: assert property (idle_q > 6'h20 |-> !o_transmit_delimiter_pulse) else $error("tx no cause");
  cover property (o_soft_link_restart);
  cover property (o_receive_delimiter_pulse);
  cover property (o_pin_sfd == 2'h2);
endmodule

/* testbench/fdt_frame_delimiter_timestamp_pulse_bench.sv */
/* bench for the delimiter pulse block.
 drives inputs at the falling edge; mac model counts pulses. */
`timescale 1ns/1ps
module fdt_frame_delimiter_timestamp_pulse_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, txd = 0, rxd = 0, up = 0, g = 0, ms = 0;
  logic [8:0] addr = 9'h000;
  logic [15:0] wd = 16'h0000;
  logic [3:0] skew = 4'h0;
  wire [15:0] rdat;
  wire rs, txp, rxp;
  wire [1:0] pins;
  int err_total = 0, check_count = 0, cyc = 0;
  fdt_frame_delimiter_pulse fdt_frame_delimiter_pulse_i (.i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_tx_delim(txd), .i_rx_first_sym(rxd), .i_link_up(up),
    .i_speed_1000(g), .i_role_master(ms), .i_pair_skew(skew), .o_soft_link_restart(rs),
    .o_transmit_delimiter_pulse(txp), .o_receive_delimiter_pulse(rxp), .o_pin_sfd(pins));
  fdt_mac fdt_mac_i (.i_clk(clk), .i_tx_pulse(txp), .i_rx_pulse(rxp));
  initial forever #10 clk = ~clk;
  task check(string n, logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task wrr(logic [8:0] a, logic [15:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk) wr = 0;
  endtask
  task rdc(string n, logic [8:0] a, logic [15:0] e);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk) rd = 0;
    check(n, rdat, e);
  endtask
  // one delimiter event, first pulse delay and pin activity
  task pulse(logic r, int e, logic [1:0] ep);
    int s;
    logic [1:0] p;
    s = 0;
    p = 2'h0;
    @(negedge clk);
    txd = !r;
    rxd = r;
    for (int n = 1; n <= 40; n++) begin
      @(negedge clk);
      txd = 0;
      rxd = 0;
      if ((r ? rxp : txp) === 1'b1 && s == 0) s = n - 1; // edges after the taking edge
      p = p | pins;
    end
    check("delay", 16'(s), 16'(e));
    check("pins", {14'h0000, p}, {14'h0000, ep});
  endtask
  task t_regs;
    rdc("receive_config", 9'h134, 16'h0000);
    rdc("pinsel", 9'h1E0, 16'h0000);
    rdc("unmapped", 9'h100, 16'h0000);
    wrr(9'h055, 16'hFFFF);
    rdc("skew ro", 9'h055, 16'h0000);
    pulse(0, 0, 2'h0);
    wrr(9'h134, 16'h0080);
    rdc("receive_config", 9'h134, 16'h0080);
    $display("regs done");
  endtask
  task t_phase;
    pulse(0, 1, 2'h0);
    pulse(1, 1, 2'h0);
    wrr(9'h1E1, 16'h0003);
    pulse(0, 4, 2'h0);
    wrr(9'h1E0, 16'h0021);
    pulse(0, 4, 2'h1);
    pulse(1, 4, 2'h2);
    wrr(9'h1E1, 16'h0000);
    $display("phase done");
  endtask
  task t_skew;
    wrr(9'h0E9, 16'hDF22);
    g = 1;
    ms = 1;
    skew = 4'h5;
    @(negedge clk) up = 1;
    @(negedge clk) skew = 4'h9;
    rdc("master", 9'h055, 16'h0050);
    pulse(1, 6, 2'h2);
    @(negedge clk) up = 0;
    ms = 0;
    skew = 4'h3;
    @(negedge clk) up = 1;
    rdc("slave", 9'h055, 16'h0003);
    pulse(1, 4, 2'h2);
    skew = 4'h2;
    wrr(9'h01F, 16'h4000);
    check("restart", {15'h0000, rs}, 16'h0001);
    @(negedge clk);
    rdc("relink", 9'h055, 16'h0002);
    @(negedge clk) up = 0;
    g = 0;
    @(negedge clk) up = 1;
    rdc("fast", 9'h055, 16'h0000);
    pulse(1, 1, 2'h2);
    $display("skew done");
  endtask
  task summarize;
    $display("checks %0d wrong %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    t_regs();
    t_phase();
    t_skew();
    check("tx count", 16'(fdt_mac_i.tx_n), 16'h0003);
    check("rx count", 16'(fdt_mac_i.rx_n), 16'h0005);
    summarize();
  end
endmodule
bind fdt_frame_delimiter_pulse fdt_chk fdt_chk_i (.i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .i_tx_delim, .o_soft_link_restart, .o_transmit_delimiter_pulse, .o_receive_delimiter_pulse, .o_pin_sfd);

/* testbench/fdt_mac.sv */
/* mac timestamp unit model: counts delimiter pulses.
 assumes single-cycle strobes on i_clk. */
`timescale 1ns/1ps
module fdt_mac (
  input wire i_clk,
  input wire i_tx_pulse,
  input wire i_rx_pulse
);
  int tx_n = 0;
  int rx_n = 0;
  // one timestamp event per pulse
  always @(posedge i_clk) begin
    tx_n <= tx_n + int'(i_tx_pulse);
    rx_n <= rx_n + int'(i_rx_pulse);
  end
endmodule
